/* File: fsp_host_model.sv */
// Purpose: serial host model for the flash status protection link
// Assumes: mode 0, sclk period 200 ns against a 25 ns clk_i
// Notes: sclk stands low between frames
`timescale 1ns/1ps
module fsp_host_model (
   input wire logic clk_i,
   input wire logic miso_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic mosi_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b1;
   end
   task automatic half();
      repeat (4) @(negedge clk_i);
   endtask
   // whole bytes, msb first; protect pin is driven, never strapped
   task automatic frame(input int n, input logic [31:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      cs_n_o = 1'b0;
      for (int i = 0; i < n * 8; i++) begin
         mosi_o = tx[31 - i];
         half();
         sclk_o = 1'b1;
         half();
         rx = {rx[6:0], miso_i};
         sclk_o = 1'b0;
      end
      // released data line flips so a stale bit cannot pass for data
      mosi_o = ~mosi_o;
      half();
      cs_n_o = 1'b1;
      repeat (8) @(negedge clk_i);
   endtask
endmodule

/* File: fsp_pkg.sv */
// Purpose: shared constants and types for the flash status protection logic
// Assumes: 1 MB array, 20-bit byte addresses, single-wire serial command link
// Notes: status word bit positions follow the combined 16-bit status word
package fsp_pkg;
   // status word bit positions
   localparam int unsigned BUSY_POS = 0;
   localparam int unsigned WEL_POS = 1;
   localparam int unsigned BP_LSB = 2;
   localparam int unsigned TB_POS = 5;
   localparam int unsigned SEC_POS = 6;
   localparam int unsigned LOCKL_POS = 7;
   localparam int unsigned LOCKH_POS = 8;
   localparam int unsigned QE_POS = 9;
   localparam int unsigned LB_LSB = 10;
   localparam int unsigned CMP_POS = 14;
   localparam int unsigned SUS_POS = 15;

   // factory values of the stored fields
   localparam logic [2:0] BP_RESET = 3'h0;
   localparam logic [1:0] LOCK_RESET = 2'h0;
   localparam logic [3:0] LB_RESET = 4'h0;
   localparam logic TB_RESET = 1'b0;
   localparam logic SEC_RESET = 1'b0;
   localparam logic CMP_RESET = 1'b0;
   localparam logic QE_RESET = 1'b0;

   // lock-mode encodings
   localparam logic [1:0] LOCK_SOFT = 2'h0;
   localparam logic [1:0] LOCK_PIN = 2'h1;
   localparam logic [1:0] LOCK_POWER = 2'h2;
   localparam logic [1:0] LOCK_OTP = 2'h3;

   // instruction codes
   localparam logic [7:0] OPC_WREN = 8'h06;
   localparam logic [7:0] OPC_WRDI = 8'h04;
   localparam logic [7:0] OPC_RD_LO = 8'h05;
   localparam logic [7:0] OPC_RD_HI = 8'h35;
   localparam logic [7:0] OPC_WR_STAT = 8'h01;
   localparam logic [7:0] OPC_PAGE = 8'h02;
   localparam logic [7:0] OPC_QPAGE = 8'h32;
   localparam logic [7:0] OPC_SECTOR = 8'h20;
   localparam logic [7:0] OPC_BLK32 = 8'h52;
   localparam logic [7:0] OPC_BLK64 = 8'hd8;
   localparam logic [7:0] OPC_CHIP_A = 8'hc7;
   localparam logic [7:0] OPC_CHIP_B = 8'h60;
   localparam logic [7:0] OPC_SUSPEND = 8'h75;
   localparam logic [7:0] OPC_RESUME = 8'h7a;

   // region sizes in bytes
   localparam int unsigned ADDR_W = 20;
   localparam logic [20:0] ARRAY_BYTES = 21'h100000;
   localparam logic [20:0] SECTOR_BYTES = 21'h001000;
   localparam logic [20:0] HALF_BLOCK_BYTES = 21'h008000;
   localparam logic [20:0] BLOCK_BYTES = 21'h010000;
   localparam logic [20:0] PAGE_BYTES = 21'h000100;

   // byte counts a command needs before its ending edge counts
   localparam logic [2:0] STAT_LO_BYTES = 3'h2;
   localparam logic [2:0] STAT_HI_BYTES = 3'h3;
   localparam logic [2:0] ADDR_CMD_BYTES = 3'h4;
   localparam logic [2:0] ONE_BYTE = 3'h1;
   localparam logic [2:0] BYTE_SAT = 3'h7;

   typedef enum logic [2:0] {
      OP_PAGE,
      OP_SECTOR,
      OP_BLK32,
      OP_BLK64,
      OP_CHIP
   } fsp_op_type;
endpackage

/* File: fsp_range_check.sv */
// Purpose: decide whether an erase/program byte range touches protected memory
// Assumes: range given as first and last byte address, both inside the array
// Notes: purely combinational; caller samples the verdict before issuing
`timescale 1ns/1ps
module fsp_range_check (
   input wire logic sec_i,
   input wire logic tb_i,
   input wire logic cmp_i,
   input wire logic [2:0] bp_i,
   input wire logic [19:0] first_i,
   input wire logic [19:0] last_i,
   output logic hit_o
);
   // size of the base region chosen by granularity and block-protect code
   function automatic logic [20:0] region_size(input logic sec, input logic [2:0] bp);
      logic [20:0] sz;
      sz = '0;
      if (bp == 3'h0) begin
         sz = '0;
      end else if (!sec) begin
         // 64KB blocks, codes above 100 take the whole array
         if (bp > 3'h4) begin
            sz = fsp_pkg::ARRAY_BYTES;
         end else begin
            sz = fsp_pkg::BLOCK_BYTES << (bp - 3'h1);
         end
      end else begin
         // 4KB sectors; 10x saturates at 32KB, 11x covers everything
         if (bp[2:1] == 2'h3) begin
            sz = fsp_pkg::ARRAY_BYTES;
         end else if (bp[2]) begin
            sz = fsp_pkg::HALF_BLOCK_BYTES;
         end else begin
            sz = fsp_pkg::SECTOR_BYTES << (bp - 3'h1);
         end
      end
      return sz;
   endfunction

   logic [20:0] size;
   logic [20:0] lo;
   logic [20:0] hi;
   logic [20:0] first_w;
   logic [20:0] last_w;

   always_comb begin
      size = region_size(sec_i, bp_i);
      first_w = {1'b0, first_i};
      last_w = {1'b0, last_i};
      // top end when select is 0, bottom end when 1
      if (tb_i) begin
         lo = '0;
         hi = size - 21'h1;
      end else begin
         lo = fsp_pkg::ARRAY_BYTES - size;
         hi = fsp_pkg::ARRAY_BYTES - 21'h1;
      end
      if (!cmp_i) begin
         hit_o = (size != '0) && (first_w <= hi) && (last_w >= lo);
      end else begin
         // inverted set: everything outside the base region is read-only
         hit_o = (size == '0) || (first_w < lo) || (last_w > hi);
      end
   end
endmodule

/* File: fsp_status_protect.sv */
// Purpose: status-register protection logic of a serial flash
// Assumes: link pins sampled by clk_i; reset models a power cycle
// Notes: no non-volatile storage here; reset loads the factory values
// Notes on behaviour
// - top/bottom select: 0 top end, 1 bottom
// - factory: top/bottom, granularity, invert all zero
// - top/bottom changes only through permitted status write
// - granularity 1 counts 4KB, 0 counts 64KB
// - invert bit lives at status bit 14
// - invert set flips protected and writable areas
// - lock-mode bits at status bits 8 and 7
// - mode 00 ignores pin, needs write latch
// - mode 01 refuses while pin low
// - mode 10 refuses until power cycle clears
// - mode 11 refuses status writes until power cycle clears
// - suspend 75h sets pause flag, bit 15
// - resume 7Ah while array not busy, or power cycle, clears flag
// - lock bits 13..10, default 0, set individually
// - lock bits never cleared by a write; only power cycle clears them
// - four-wire enable at bit 9, factory 0
// - four-wire enable repurposes the protect pin
// - 64KB sizes per code, 101/11x whole array
// - 4KB..32KB sizes, 11x whole array
// - protected-range erase or program is discarded
// - block-protect bits 4..2, factory 0
// - write latch set by enable, cleared by disable or after accepted writes; refused writes keep it
`timescale 1ns/1ps
module fsp_status_protect (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic mosi_i,
   input wire logic wp_n_i,
   input wire logic array_busy_i,
   output logic miso_o,
   output logic miso_oe_n_o,
   output logic op_valid_o,
   output fsp_pkg::fsp_op_type op_kind_o,
   output logic [19:0] op_first_o,
   output logic [19:0] op_last_o,
   output logic op_refused_o,
   output logic [15:0] status_o,
   output logic four_wire_enable_o,
   output logic [3:0] secure_lock_o
);
   // pin synchronisers: first stage is read only by the second
   logic [3:0] meta_ff;
   logic [3:0] sync_ff;
   logic sclk_d_ff;
   logic cs_d_ff;
   logic cs_s;
   logic sclk_s;
   logic mosi_s;
   logic wp_n_s;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_start;
   logic cs_end;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= 4'hf;
         sync_ff <= 4'hf;
         sclk_d_ff <= 1'b1;
         cs_d_ff <= 1'b1;
      end else if (ce_i) begin
         meta_ff <= {cs_n_i, sclk_i, mosi_i, wp_n_i};
         sync_ff <= meta_ff;
         sclk_d_ff <= sync_ff[2];
         cs_d_ff <= sync_ff[3];
      end
   end

   assign cs_s = sync_ff[3];
   assign sclk_s = sync_ff[2];
   assign mosi_s = sync_ff[1];
   assign wp_n_s = sync_ff[0];
   assign sclk_rise = !cs_s && sclk_s && !sclk_d_ff;
   assign sclk_fall = !cs_s && !sclk_s && sclk_d_ff;
   assign cs_start = !cs_s && cs_d_ff;
   assign cs_end = cs_s && !cs_d_ff;

   // stored status fields
   logic [2:0] bp_ff;
   logic tb_ff;
   logic sec_ff;
   logic cmp_ff;
   logic [1:0] lock_ff;
   logic qe_ff;
   logic [3:0] lb_ff;
   logic sus_ff;
   logic wel_ff;
   logic [15:0] stat_w;

   // bit positions set by the package
   always_comb begin
      stat_w = '0;
      stat_w[fsp_pkg::BUSY_POS] = array_busy_i;
      stat_w[fsp_pkg::WEL_POS] = wel_ff;
      stat_w[fsp_pkg::BP_LSB +: 3] = bp_ff;
      stat_w[fsp_pkg::TB_POS] = tb_ff;
      stat_w[fsp_pkg::SEC_POS] = sec_ff;
      stat_w[fsp_pkg::LOCKL_POS] = lock_ff[0];
      stat_w[fsp_pkg::LOCKH_POS] = lock_ff[1];
      stat_w[fsp_pkg::QE_POS] = qe_ff;
      stat_w[fsp_pkg::LB_LSB +: 4] = lb_ff;
      stat_w[fsp_pkg::CMP_POS] = cmp_ff;
      stat_w[fsp_pkg::SUS_POS] = sus_ff;
   end

   // receive shifter and byte counting
   logic [6:0] rx_ff;
   logic [2:0] bit_ff;
   logic [2:0] byte_ff;
   logic [7:0] opc_ff;
   logic [23:0] addr_ff;
   logic [7:0] wr_lo_ff;
   logic [7:0] wr_hi_ff;
   logic [7:0] rx_byte;
   logic byte_done;

   assign rx_byte = {rx_ff, mosi_s};
   assign byte_done = sclk_rise && (bit_ff == 3'h7);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_ff <= '0;
         bit_ff <= '0;
         byte_ff <= '0;
      end else if (ce_i) begin
         if (cs_start) begin
            bit_ff <= '0;
            byte_ff <= '0;
         end else if (sclk_rise) begin
            rx_ff <= rx_byte[6:0];
            bit_ff <= bit_ff + 3'h1;
            // saturate so long page data cannot wrap the count
            if (byte_done && byte_ff != fsp_pkg::BYTE_SAT) begin
               byte_ff <= byte_ff + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         opc_ff <= '0;
         addr_ff <= '0;
         wr_lo_ff <= '0;
         wr_hi_ff <= '0;
      end else if (ce_i) begin
         if (cs_start) begin
            opc_ff <= '0;
         end else if (byte_done) begin
            case (byte_ff)
               3'h0: opc_ff <= rx_byte;
               3'h1: begin
                  addr_ff[23:16] <= rx_byte;
                  wr_lo_ff <= rx_byte;
               end
               3'h2: begin
                  addr_ff[15:8] <= rx_byte;
                  wr_hi_ff <= rx_byte;
               end
               3'h3: addr_ff[7:0] <= rx_byte;
               default: ;
            endcase
         end
      end
   end

   // status read-out: reload at every byte boundary so repeated bytes stay live
   logic [7:0] tx_ff;
   logic rd_ff;
   logic rd_hi_ff;
   logic miso_ff;
   logic miso_oe_n_ff;
   logic [7:0] rd_byte;

   always_comb begin
      if (byte_ff == 3'h0) begin
         rd_byte = (rx_byte == fsp_pkg::OPC_RD_HI) ? stat_w[15:8] : stat_w[7:0];
      end else begin
         rd_byte = rd_hi_ff ? stat_w[15:8] : stat_w[7:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_ff <= '0;
         rd_ff <= 1'b0;
         rd_hi_ff <= 1'b0;
         miso_ff <= 1'b0;
         miso_oe_n_ff <= 1'b1;
      end else if (ce_i) begin
         if (cs_s) begin
            rd_ff <= 1'b0;
            miso_oe_n_ff <= 1'b1;
         end else if (byte_done && byte_ff == 3'h0) begin
            rd_ff <= (rx_byte == fsp_pkg::OPC_RD_LO) || (rx_byte == fsp_pkg::OPC_RD_HI);
            rd_hi_ff <= (rx_byte == fsp_pkg::OPC_RD_HI);
            tx_ff <= rd_byte;
         end else if (byte_done && rd_ff) begin
            tx_ff <= rd_byte;
         end else if (sclk_fall && rd_ff) begin
            miso_ff <= tx_ff[7];
            miso_oe_n_ff <= 1'b0;
            tx_ff <= {tx_ff[6:0], 1'b0};
         end
      end
   end

   // command completion at the end of the frame
   logic whole_bytes;
   logic is_chip;
   logic is_addr_op;
   logic ignore_busy;
   logic stat_wr_ok;
   logic pin_high;
   fsp_pkg::fsp_op_type kind;
   logic [20:0] span;
   logic [19:0] first_w;
   logic [19:0] last_w;
   logic hit;

   assign whole_bytes = (bit_ff == 3'h0);
   assign is_chip = (opc_ff == fsp_pkg::OPC_CHIP_A) || (opc_ff == fsp_pkg::OPC_CHIP_B);
   assign ignore_busy = array_busy_i;
   // with four-wire enabled the protect pin is a data line and counts as high
   assign pin_high = qe_ff || wp_n_s;

   always_comb begin
      // lock mode decides the pin role and whether writes go through
      case (lock_ff)
         fsp_pkg::LOCK_SOFT: stat_wr_ok = wel_ff;
         fsp_pkg::LOCK_PIN: stat_wr_ok = wel_ff && pin_high;
         fsp_pkg::LOCK_POWER: stat_wr_ok = 1'b0;
         fsp_pkg::LOCK_OTP: stat_wr_ok = 1'b0;
         default: stat_wr_ok = 1'b0;
      endcase
   end

   always_comb begin
      is_addr_op = 1'b1;
      kind = fsp_pkg::OP_PAGE;
      span = fsp_pkg::PAGE_BYTES;
      case (opc_ff)
         fsp_pkg::OPC_PAGE, fsp_pkg::OPC_QPAGE: begin
            kind = fsp_pkg::OP_PAGE;
            span = fsp_pkg::PAGE_BYTES;
         end
         fsp_pkg::OPC_SECTOR: begin
            kind = fsp_pkg::OP_SECTOR;
            span = fsp_pkg::SECTOR_BYTES;
         end
         fsp_pkg::OPC_BLK32: begin
            kind = fsp_pkg::OP_BLK32;
            span = fsp_pkg::HALF_BLOCK_BYTES;
         end
         fsp_pkg::OPC_BLK64: begin
            kind = fsp_pkg::OP_BLK64;
            span = fsp_pkg::BLOCK_BYTES;
         end
         default: begin
            is_addr_op = 1'b0;
            kind = fsp_pkg::OP_CHIP;
            span = fsp_pkg::ARRAY_BYTES;
         end
      endcase
      if (is_chip) begin
         first_w = '0;
      end else begin
         // align down to the unit so the check sees the whole target
         first_w = addr_ff[19:0] & ~(span[19:0] - 20'h1);
      end
      last_w = first_w + (span[19:0] - 20'h1);
   end

   // verdict from the live fields, sampled on the frame end
   fsp_range_check u_check (
      .sec_i(sec_ff),
      .tb_i(tb_ff),
      .cmp_i(cmp_ff),
      .bp_i(bp_ff),
      .first_i(first_w),
      .last_i(last_w),
      .hit_o(hit)
   );

   logic do_wren;
   logic do_wrdi;
   logic do_stat;
   logic do_array;

   assign do_wren = cs_end && whole_bytes && !ignore_busy && (byte_ff == fsp_pkg::ONE_BYTE)
                    && (opc_ff == fsp_pkg::OPC_WREN);
   assign do_wrdi = cs_end && whole_bytes && !ignore_busy && (byte_ff == fsp_pkg::ONE_BYTE)
                    && (opc_ff == fsp_pkg::OPC_WRDI);
   assign do_stat = cs_end && whole_bytes && !ignore_busy && (opc_ff == fsp_pkg::OPC_WR_STAT)
                    && (byte_ff >= fsp_pkg::STAT_LO_BYTES) && stat_wr_ok;
   assign do_array = cs_end && whole_bytes && !ignore_busy && wel_ff
                     && ((is_addr_op && byte_ff >= fsp_pkg::ADDR_CMD_BYTES)
                         || (is_chip && byte_ff == fsp_pkg::ONE_BYTE));

   // status fields change only through an accepted status write
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bp_ff <= fsp_pkg::BP_RESET;
         tb_ff <= fsp_pkg::TB_RESET;
         sec_ff <= fsp_pkg::SEC_RESET;
         cmp_ff <= fsp_pkg::CMP_RESET;
         lock_ff <= fsp_pkg::LOCK_RESET; // power cycle returns lock mode to 00
         qe_ff <= fsp_pkg::QE_RESET;
         lb_ff <= fsp_pkg::LB_RESET;
      end else if (ce_i && do_stat) begin
         bp_ff <= wr_lo_ff[fsp_pkg::BP_LSB +: 3];
         tb_ff <= wr_lo_ff[fsp_pkg::TB_POS];
         sec_ff <= wr_lo_ff[fsp_pkg::SEC_POS];
         lock_ff[0] <= wr_lo_ff[fsp_pkg::LOCKL_POS];
         // a one-byte write leaves the high byte untouched
         if (byte_ff >= fsp_pkg::STAT_HI_BYTES) begin
            lock_ff[1] <= wr_hi_ff[fsp_pkg::LOCKH_POS - 8];
            qe_ff <= wr_hi_ff[fsp_pkg::QE_POS - 8];
            cmp_ff <= wr_hi_ff[fsp_pkg::CMP_POS - 8];
            // locks can only be added, never removed
            lb_ff <= lb_ff | wr_hi_ff[fsp_pkg::LB_LSB - 8 +: 4];
         end
      end
   end

   // write latch: enable sets, disable or a finished write clears
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wel_ff <= 1'b0;
      end else if (ce_i) begin
         if (do_wren) begin
            wel_ff <= 1'b1;
         end else if (do_wrdi || do_stat || (do_array && !hit)) begin
            wel_ff <= 1'b0;
         end
      end
   end

   // pause flag: read only, so only instructions move it
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sus_ff <= 1'b0;
      end else if (ce_i && cs_end && whole_bytes && byte_ff == fsp_pkg::ONE_BYTE) begin
         if (opc_ff == fsp_pkg::OPC_SUSPEND) begin
            sus_ff <= 1'b1;
         end else if (opc_ff == fsp_pkg::OPC_RESUME && !array_busy_i) begin
            sus_ff <= 1'b0;
         end
      end
   end

   // array request: refused ones never reach op_valid_o
   logic op_valid_ff;
   logic op_refused_ff;
   fsp_pkg::fsp_op_type op_kind_ff;
   logic [19:0] op_first_ff;
   logic [19:0] op_last_ff;
   logic [15:0] status_ff;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         op_valid_ff <= 1'b0;
         op_refused_ff <= 1'b0;
         op_kind_ff <= fsp_pkg::OP_PAGE;
         op_first_ff <= '0;
         op_last_ff <= '0;
      end else if (ce_i) begin
         op_valid_ff <= do_array && !hit;
         op_refused_ff <= do_array && hit;
         if (do_array) begin
            op_kind_ff <= kind;
            op_first_ff <= first_w;
            op_last_ff <= last_w;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_ff <= '0;
      end else if (ce_i) begin
         status_ff <= stat_w;
      end
   end

   assign miso_o = miso_ff;
   assign miso_oe_n_o = miso_oe_n_ff;
   assign op_valid_o = op_valid_ff;
   assign op_refused_o = op_refused_ff;
   assign op_kind_o = op_kind_ff;
   assign op_first_o = op_first_ff;
   assign op_last_o = op_last_ff;
   assign status_o = status_ff;
   assign four_wire_enable_o = qe_ff;
   assign secure_lock_o = lb_ff;
endmodule

/* File: fsp_status_protect_assertions.sv */
// Purpose: port-level checks of the status protection block
// Assumes: one clock domain, reset models a power cycle
// Notes: status_o trails the stored fields by one cycle
`timescale 1ns/1ps
module fsp_status_protect_assertions (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic wp_n_i,
   input wire logic op_valid_o,
   input wire fsp_pkg::fsp_op_type op_kind_o,
   input wire logic [19:0] op_first_o,
   input wire logic [19:0] op_last_o,
   input wire logic op_refused_o,
   input wire logic [15:0] status_o,
   input wire logic [3:0] secure_lock_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   AST_ONE_VERDICT: assert property (!(op_valid_o && op_refused_o))
      else $error("valid and refused together");
   AST_WEL_CLEARED: assert property (op_valid_o && ce_i |=> !status_o[1])
      else $error("latch kept after accepted op");
   AST_WEL_KEPT: assert property (op_refused_o && ce_i |=> status_o[1])
      else $error("latch lost after refused op");
   AST_SECTOR_RANGE: assert property (
      op_valid_o && op_kind_o == fsp_pkg::OP_SECTOR |->
      op_first_o[11:0] == 12'h000 && op_last_o == op_first_o + 20'h00fff)
      else $error("sector range wrong");
   AST_LOCK_STICKY: assert property (
      ($past(secure_lock_o) & ~secure_lock_o) == 4'h0)
      else $error("lock bit cleared");
   AST_POWER_LOCK: assert property (
      status_o[8:7] == 2'h2 |=> $stable(status_o[14:2]))
      else $error("write in power lock");
   AST_OTP_LOCK: assert property (
      status_o[8:7] == 2'h3 |=> $stable(status_o[14:2]))
      else $error("write in permanent lock");
   AST_PIN_LOCK: assert property (
      (status_o[8:7] == 2'h1 && !status_o[9] && !wp_n_i) [*5] |=> $stable(status_o[14:2]))
      else $error("write with protect pin low");
   AST_NONE_PROTECTED: assert property (
      op_refused_o |-> status_o[4:2] != 3'h0 || status_o[14])
      else $error("refused with nothing protected");
endmodule
bind fsp_status_protect fsp_status_protect_assertions u_fsp_status_protect_assertions (
   .clk_i, .rst_n_i, .ce_i, .wp_n_i, .op_valid_o, .op_kind_o, .op_first_o, .op_last_o,
   .op_refused_o, .status_o, .secure_lock_o);

/* File: testbench.sv */
// Purpose: self-checking bench for fsp_status_protect
// Assumes: host model drives the link, bench drives the pins around it
// Notes: a reset stands in for a power cycle
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
   $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module testbench;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wp_n_i = 1'b1;
   logic busy = 1'b0;
   logic cs_n, sclk, mosi, miso, miso_oe_n, op_valid, op_refused, four_wire;
   fsp_pkg::fsp_op_type op_kind;
   logic [19:0] op_first, op_last;
   logic [15:0] status;
   logic [3:0] lock;
   logic [7:0] rx;
   int n_fail = 0;
   int total_checks = 0;
   int n_ok = 0;
   int n_ref = 0;
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (op_valid === 1'b1) n_ok++;
      if (op_refused === 1'b1) n_ref++;
   end
   fsp_host_model u_fsp_host_model (.clk_i(clk_i), .miso_i(miso), .cs_n_o(cs_n),
      .sclk_o(sclk), .mosi_o(mosi));
   fsp_status_protect u_fsp_status_protect (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
      .cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi), .wp_n_i(wp_n_i), .array_busy_i(busy),
      .miso_o(miso), .miso_oe_n_o(miso_oe_n), .op_valid_o(op_valid), .op_kind_o(op_kind),
      .op_first_o(op_first), .op_last_o(op_last), .op_refused_o(op_refused),
      .status_o(status), .four_wire_enable_o(four_wire), .secure_lock_o(lock));
   task automatic complete_run();
      if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic power_cycle();
      rst_n_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (2) @(negedge clk_i);
   endtask
   task automatic cmd(input int n, input logic [31:0] tx);
      u_fsp_host_model.frame(n, tx, rx);
   endtask
   task automatic wr_stat(input logic [7:0] lo, input logic [7:0] hi);
      cmd(1, {fsp_pkg::OPC_WREN, 24'h000000});
      cmd(3, {fsp_pkg::OPC_WR_STAT, lo, hi, 8'h00});
   endtask
   task automatic prot(input logic [7:0] lo, input logic [7:0] hi, input logic [19:0] a,
      input logic exp_ref);
      int r;
      wr_stat(lo, hi);
      cmd(1, {fsp_pkg::OPC_WREN, 24'h000000});
      r = n_ref;
      cmd(4, {fsp_pkg::OPC_SECTOR, 4'h0, a});
      `CHK("refused", exp_ref, logic'(n_ref != r))
   endtask
   task automatic t_reset();
      `CHK("status", 16'h0000, status)
      cmd(2, {fsp_pkg::OPC_RD_LO, 24'h000000});
      `CHK("rd_lo", 8'h00, rx)
      cmd(2, {fsp_pkg::OPC_RD_HI, 24'h000000});
      `CHK("rd_hi", 8'h00, rx)
      `CHK("oe_off", 1'b1, miso_oe_n)
   endtask
   task automatic t_erase();
      int v;
      cmd(1, {fsp_pkg::OPC_WREN, 24'h000000});
      `CHK("wel", 1'b1, status[1])
      v = n_ok;
      cmd(4, {fsp_pkg::OPC_SECTOR, 24'h0a5123});
      `CHK("valid", 1'b1, logic'(n_ok == v + 1))
      `CHK("kind", fsp_pkg::OP_SECTOR, op_kind)
      `CHK("first", 20'ha5000, op_first)
      `CHK("last", 20'ha5fff, op_last)
      `CHK("wel_clr", 1'b0, status[1])
      cmd(1, {fsp_pkg::OPC_WREN, 24'h000000});
      cmd(4, {fsp_pkg::OPC_PAGE, 24'h012345});
      `CHK("pg_kind", fsp_pkg::OP_PAGE, op_kind)
      `CHK("pg_first", 20'h12300, op_first)
      `CHK("pg_last", 20'h123ff, op_last)
      cmd(1, {fsp_pkg::OPC_WREN, 24'h000000});
      cmd(4, {fsp_pkg::OPC_BLK64, 24'h0a5123});
      `CHK("b64_kind", fsp_pkg::OP_BLK64, op_kind)
      `CHK("b64_first", 20'ha0000, op_first)
      `CHK("b64_last", 20'haffff, op_last)
      cmd(1, {fsp_pkg::OPC_WREN, 24'h000000});
      v = n_ok;
      cmd(1, {fsp_pkg::OPC_CHIP_A, 24'h000000});
      `CHK("chip_valid", 1'b1, logic'(n_ok == v + 1))
      `CHK("chip_kind", fsp_pkg::OP_CHIP, op_kind)
      `CHK("chip_first", 20'h00000, op_first)
      `CHK("chip_last", 20'hfffff, op_last)
   endtask
   task automatic t_table();
      prot(8'h04, 8'h00, 20'hf0000, 1'b1);
      prot(8'h04, 8'h00, 20'hef000, 1'b0);
      prot(8'h24, 8'h00, 20'h0f000, 1'b1);
      prot(8'h24, 8'h00, 20'h10000, 1'b0);
      prot(8'h10, 8'h00, 20'h80000, 1'b1);
      prot(8'h10, 8'h00, 20'h7f000, 1'b0);
      prot(8'h14, 8'h00, 20'h00000, 1'b1);
      prot(8'h44, 8'h00, 20'hff000, 1'b1);
      prot(8'h44, 8'h00, 20'hfe000, 1'b0);
      prot(8'h70, 8'h00, 20'h07000, 1'b1);
      prot(8'h70, 8'h00, 20'h08000, 1'b0);
      prot(8'h5c, 8'h00, 20'h00000, 1'b1);
      prot(8'h04, 8'h40, 20'hf0000, 1'b0);
      prot(8'h04, 8'h40, 20'hef000, 1'b1);
      prot(8'h00, 8'h00, 20'h00000, 1'b0);
   endtask
   task automatic t_locks();
      wp_n_i = 1'b0;
      cmd(3, {fsp_pkg::OPC_WR_STAT, 8'h04, 8'h00, 8'h00});
      `CHK("no_wel", 3'h0, status[4:2])
      wr_stat(8'h80, 8'h00);
      `CHK("mode01", 2'h1, status[8:7])
      wr_stat(8'h84, 8'h00);
      `CHK("wp_low", 3'h0, status[4:2])
      wp_n_i = 1'b1;
      wr_stat(8'h88, 8'h00);
      `CHK("wp_high", 3'h2, status[4:2])
      wr_stat(8'h88, 8'h02);
      `CHK("qe", 1'b1, four_wire)
      wp_n_i = 1'b0;
      wr_stat(8'h8c, 8'h02);
      `CHK("qe_pin", 3'h3, status[4:2])
      wr_stat(8'h00, 8'h01);
      `CHK("mode10", 2'h2, status[8:7])
      wr_stat(8'h24, 8'h00);
      `CHK("frozen", 14'h0040, status[15:2])
      power_cycle();
      `CHK("unlocked", 2'h0, status[8:7])
      wp_n_i = 1'b1;
      wr_stat(8'h80, 8'h01);
      wr_stat(8'h04, 8'h00);
      `CHK("otp", 14'h0060, status[15:2])
      power_cycle();
   endtask
   task automatic t_secure();
      wr_stat(8'h00, 8'h04);
      `CHK("lock0", 4'h1, lock)
      wr_stat(8'h00, 8'h20);
      `CHK("lock3", 4'h9, lock)
      wr_stat(8'h00, 8'h00);
      `CHK("sticky", 4'h9, lock)
   endtask
   task automatic t_suspend();
      busy = 1'b1;
      cmd(1, {fsp_pkg::OPC_SUSPEND, 24'h000000});
      `CHK("sus_set", 1'b1, status[15])
      cmd(1, {fsp_pkg::OPC_RESUME, 24'h000000});
      `CHK("sus_busy", 1'b1, status[15])
      busy = 1'b0;
      cmd(2, {fsp_pkg::OPC_RD_HI, 24'h000000});
      `CHK("rd_sus", 1'b1, rx[7])
      cmd(1, {fsp_pkg::OPC_RESUME, 24'h000000});
      `CHK("sus_clr", 1'b0, status[15])
      cmd(1, {fsp_pkg::OPC_SUSPEND, 24'h000000});
      power_cycle();
      `CHK("sus_pwr", 1'b0, status[15])
   endtask
   initial begin
      repeat (4) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (2) @(negedge clk_i);
      t_reset();
      t_erase();
      t_table();
      t_locks();
      t_secure();
      t_suspend();
      complete_run();
   end
   // about five times the expected run length
   initial begin
      #2000000;
      n_fail++;
      complete_run();
   end
endmodule
